// File: lpcc_pkg.sv
// Shared constants and types for the LED PWM channel controller
package lpcc_pkg;

  localparam int          NUM_CH        = 12;
  // Register offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PWM_BASE  = 8'h07;
  localparam logic [7:0] OFS_SCALE     = 8'h4D;
  localparam logic [7:0] OFS_GCC       = 8'h6E;
  localparam logic [7:0] OFS_FDET      = 8'h71;
  localparam logic [7:0] OFS_FSTAT_LO  = 8'h72;
  localparam logic [7:0] OFS_FSTAT_HI  = 8'h73;
  localparam logic [7:0] OFS_SPREAD    = 8'h78;
  localparam logic [7:0] OFS_RESET     = 8'h7F;
  // Reset values and the soft reset key
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [7:0] RESET_KEY     = 8'h00;
  // Control register fields
  localparam int          CTRL_SSD_BIT  = 0;
  localparam int          CTRL_RES_LSB  = 1;
  localparam int          CTRL_OSC_LSB  = 4;
  // Fault select codes
  localparam logic [1:0] FDET_SHORT    = 2'h2;
  localparam logic [1:0] FDET_OPEN     = 2'h3;
  // Fault status field positions
  localparam int          FSTAT_LO_LSB  = 3;
  localparam int          FSTAT_LO_N    = 5;
  // Spread register field
  localparam int          SPREAD_RNG_LSB = 2;
  // PWM counter tops per resolution code
  localparam logic [15:0] TOP_8         = 16'h00FF;
  localparam logic [15:0] TOP_10        = 16'h03FF;
  localparam logic [15:0] TOP_12        = 16'h0FFF;
  localparam logic [15:0] TOP_16        = 16'hFFFF;
  // Device address on the serial bus
  localparam logic [6:0] DEV_ADDR_RST  = 7'h34;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lpcc_wr_t;

endpackage

// File: lpcc_pwm_chan.sv
// One PWM output stage comparing the shared counter with a duty value
`timescale 1ns/1ps
module lpcc_pwm_chan
  import lpcc_pkg::*;
(
  input  wire logic        clk,     // system clock
  input  wire logic        rst,     // async reset, high
  input  wire logic [15:0] count,   // shared PWM counter
  input  wire logic [15:0] duty,    // masked duty value
  input  wire logic        enable,  // current source allowed on
  output logic             onOut    // channel sink on
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      onOut <= 1'b0;
    end else begin
      onOut <= enable && (count < duty);
    end
  end

endmodule // lpcc_pwm_chan

// File: lpcc_i2c_slave.sv
// Serial register-access slave with pointer auto-increment
`timescale 1ns/1ps
module lpcc_i2c_slave
  import lpcc_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // async reset, high
  input  wire logic       ifReset,  // interface-only reset pulse
  input  wire logic [6:0] devAddr,  // own 7-bit address
  input  wire logic       scl,      // serial clock in
  input  wire logic       sdaIn,    // serial data in
  output logic            sdaOut,   // serial data out level
  output logic            sdaOe,    // pull data line low
  output lpcc_wr_t        wr,       // register write pulse
  output logic [7:0]      rdAddr,   // register read pointer
  input  wire logic [7:0] rdData    // register read data
);

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08,
    S_WACK = 7'h10, S_RD   = 7'h20, S_RACK = 7'h40
  } lpcc_i2c_st_t;

  lpcc_i2c_st_t st_r;
  logic         sclQ_r;
  logic         sdaQ_r;
  logic [7:0]   sh_r;
  logic [3:0]   cnt_r;
  logic         rw_r;
  logic         first_r;
  logic         nack_r;
  logic [7:0]   ptr_r;
  logic         sclRise;
  logic         sclFall;
  logic         startC;
  logic         stopC;

  assign sclRise = scl & ~sclQ_r;
  assign sclFall = ~scl & sclQ_r;
  assign startC  = scl & sclQ_r & sdaQ_r & ~sdaIn;
  assign stopC   = scl & sclQ_r & ~sdaQ_r & sdaIn;
  assign rdAddr  = ptr_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclQ_r <= 1'b1;
      sdaQ_r <= 1'b1;
      sdaOut <= 1'b0;
    end else begin
      sclQ_r <= scl;
      sdaQ_r <= sdaIn;
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r    <= S_IDLE;
      sh_r    <= 8'h00;
      cnt_r   <= 4'h0;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      nack_r  <= 1'b0;
      ptr_r   <= 8'h00;
      sdaOe   <= 1'b0;
      wr      <= '0;
    end else if (ifReset) begin
      st_r    <= S_IDLE;
      cnt_r   <= 4'h0;
      sdaOe   <= 1'b0;
      wr      <= '0;
    end else begin
      wr.valid <= 1'b0;
      if (startC) begin
        st_r  <= S_ADDR;
        cnt_r <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopC) begin
        st_r  <= S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (st_r)
          S_IDLE: begin
          end
          S_ADDR, S_WR: begin
            if (sclRise && cnt_r < 4'h8) begin
              sh_r  <= {sh_r[6:0], sdaIn};
              cnt_r <= cnt_r + 4'h1;
            end else if (sclFall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (st_r == S_ADDR) begin
                if (sh_r[7:1] == devAddr) begin
                  st_r    <= S_AACK;
                  sdaOe   <= 1'b1;
                  rw_r    <= sh_r[0];
                  first_r <= 1'b1;
                end else begin
                  st_r <= S_IDLE;
                end
              end else begin
                st_r  <= S_WACK;
                sdaOe <= 1'b1;
                if (first_r) begin
                  ptr_r   <= sh_r;
                  first_r <= 1'b0;
                end else begin
                  wr.valid <= 1'b1;
                  wr.addr  <= ptr_r;
                  wr.data  <= sh_r;
                  ptr_r    <= ptr_r + 8'h01;
                end
              end
            end
          end
          S_AACK, S_RACK: begin
            if (sclRise) begin
              nack_r <= sdaIn;
            end
            if (sclFall) begin
              if (st_r == S_RACK && nack_r) begin
                st_r  <= S_IDLE;
                sdaOe <= 1'b0;
              end else if (rw_r) begin
                st_r  <= S_RD;
                sdaOe <= ~rdData[7];
                sh_r  <= {rdData[6:0], 1'b0};
                cnt_r <= 4'h1;
              end else begin
                st_r  <= S_WR;
                sdaOe <= 1'b0;
              end
            end
          end
          S_WACK: begin
            if (sclFall) begin
              st_r  <= S_WR;
              sdaOe <= 1'b0;
            end
          end
          S_RD: begin
            if (sclFall) begin
              if (cnt_r == 4'h8) begin
                st_r  <= S_RACK;
                sdaOe <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
              end else begin
                sdaOe <= ~sh_r[7];
                sh_r  <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          default: begin
            st_r  <= S_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // lpcc_i2c_slave

// File: lpcc_top.sv
// Twelve-channel LED PWM controller with serial register access
`timescale 1ns/1ps
module lpcc_top
  import lpcc_pkg::*;
(
  input  wire logic            ref_clk,         // 10 MHz clock
  input  wire logic            rst,             // async reset, high
  input  wire logic            hw_shutdown_n,   // shutdown pin, low = off
  input  wire logic [6:0]      devAddr,         // serial device address
  input  wire logic            scl,             // serial clock
  input  wire logic            sdaIn,           // serial data in
  output logic                 sdaOut,          // serial data out level
  output logic                 sdaOe,           // pull serial data low
  input  wire logic [11:0]     ledOpenDet,      // per-channel open sense
  input  wire logic [11:0]     ledShortDet,     // per-channel short sense
  output logic [11:0]          chanOn,          // channel sink enables
  output logic [11:0][7:0]     channel_current_scale, // per-channel scale
  output logic [7:0]           global_current,  // global current value
  output logic                 analogEn,        // analog blocks enabled
  output logic [1:0]           spread_range,    // spread range code
  output logic                 spreadEn         // spread spectrum on
);

  lpcc_wr_t          wr;
  logic [7:0]        rdAddr;
  logic [7:0]        rdData;
  logic [7:0]        ctrl_r;
  logic [11:0][7:0]  pwmLo_r;
  logic [11:0][7:0]  pwmHi_r;
  logic [11:0][7:0]  scale_r;
  logic [7:0]        gcc_r;
  logic [1:0]        fault_detect_sel;
  logic [11:0]       faultStat_r;
  logic [7:0]        spread_r;
  logic              hwQ_r;
  logic              ifRst_r;
  logic              softRst;
  logic              sw_shutdown_ctl;
  logic [1:0]        duty_resolution_sel;
  logic [2:0]        osc_freq_sel;
  logic [6:0]        oscDiv_r;
  logic [6:0]        divMask;
  logic              tick;
  logic [15:0]       pwmCnt_r;
  logic [15:0]       topVal;
  logic [11:0]       chanOnInt;
  logic              drive;

  assign sw_shutdown_ctl     = ctrl_r[CTRL_SSD_BIT];
  assign duty_resolution_sel = ctrl_r[CTRL_RES_LSB +: 2];
  assign osc_freq_sel        = ctrl_r[CTRL_OSC_LSB +: 3];
  assign drive = sw_shutdown_ctl & hw_shutdown_n;
  assign softRst = wr.valid && wr.addr == OFS_RESET
                   && wr.data == RESET_KEY
                   && hw_shutdown_n && sw_shutdown_ctl;

  // Serial interface reset on shutdown pin release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hwQ_r   <= 1'b1;
      ifRst_r <= 1'b0;
    end else begin
      hwQ_r   <= hw_shutdown_n;
      ifRst_r <= hw_shutdown_n & ~hwQ_r;
    end
  end

  lpcc_i2c_slave u_i2c (
    .clk     (ref_clk),
    .rst     (rst),
    .ifReset (ifRst_r),
    .devAddr (devAddr),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .wr      (wr),
    .rdAddr  (rdAddr),
    .rdData  (rdData)
  );

  // Register file; no shutdown term here keeps contents
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r           <= CTRL_RST;
      pwmLo_r          <= '0;
      pwmHi_r          <= '0;
      scale_r          <= '0;
      gcc_r            <= BYTE_RST;
      fault_detect_sel <= 2'h0;
      spread_r         <= BYTE_RST;
    end else if (softRst) begin
      ctrl_r           <= CTRL_RST;
      pwmLo_r          <= '0;
      pwmHi_r          <= '0;
      scale_r          <= '0;
      gcc_r            <= BYTE_RST;
      fault_detect_sel <= 2'h0;
      spread_r         <= BYTE_RST;
    end else if (wr.valid) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr.addr == OFS_PWM_BASE + 8'(2 * i)) begin
          pwmLo_r[i] <= wr.data;
        end
        if (wr.addr == OFS_PWM_BASE + 8'(2 * i + 1)) begin
          pwmHi_r[i] <= wr.data;
        end
        if (wr.addr == OFS_SCALE + 8'(i)) begin
          scale_r[i] <= wr.data;
        end
      end
      case (wr.addr)
        OFS_CTRL:   ctrl_r           <= wr.data;
        OFS_GCC:    gcc_r            <= wr.data;
        OFS_FDET:   fault_detect_sel <= wr.data[1:0];
        OFS_SPREAD: spread_r         <= wr.data;
        default: begin
        end
      endcase
    end
  end

  // Fault capture on entry into a detect code from code 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      faultStat_r <= 12'h000;
    end else if (softRst) begin
      faultStat_r <= 12'h000;
    end else if (wr.valid && wr.addr == OFS_FDET
                 && fault_detect_sel == 2'h0) begin
      if (wr.data[1:0] == FDET_SHORT) begin
        faultStat_r <= ledShortDet;
      end else if (wr.data[1:0] == FDET_OPEN) begin
        faultStat_r <= ledOpenDet;
      end
    end
  end

  // Register read mux
  always_comb begin
    rdData = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (rdAddr == OFS_PWM_BASE + 8'(2 * i)) begin
        rdData = pwmLo_r[i];
      end
      if (rdAddr == OFS_PWM_BASE + 8'(2 * i + 1)) begin
        rdData = pwmHi_r[i];
      end
      if (rdAddr == OFS_SCALE + 8'(i)) begin
        rdData = scale_r[i];
      end
    end
    case (rdAddr)
      OFS_CTRL:     rdData = ctrl_r;
      OFS_GCC:      rdData = gcc_r;
      OFS_FDET:     rdData = {6'h00, fault_detect_sel};
      OFS_FSTAT_LO: rdData = {faultStat_r[FSTAT_LO_N-1:0], 3'h0};
      OFS_FSTAT_HI: rdData = {1'b0, faultStat_r[11:FSTAT_LO_N]};
      OFS_SPREAD:   rdData = spread_r;
      default: begin
      end
    endcase
  end

  // Frequency divider and resolution-dependent counter top
  always_comb begin
    divMask = 7'((8'h01 << osc_freq_sel) - 8'h01);
    case (duty_resolution_sel)
      2'h0:    topVal = TOP_8;
      2'h1:    topVal = TOP_10;
      2'h2:    topVal = TOP_12;
      2'h3:    topVal = TOP_16;
      default: topVal = TOP_8;
    endcase
  end

  assign tick = ((oscDiv_r & divMask) == divMask);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscDiv_r <= 7'h00;
    end else begin
      oscDiv_r <= tick ? 7'h00 : oscDiv_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwmCnt_r <= 16'h0000;
    end else if (tick) begin
      pwmCnt_r <= (pwmCnt_r >= topVal) ? 16'h0000 : pwmCnt_r + 16'h0001;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : gCh
    lpcc_pwm_chan u_ch (
      .clk    (ref_clk),
      .rst    (rst),
      .count  (pwmCnt_r),
      .duty   ({pwmHi_r[g], pwmLo_r[g]} & topVal),
      .enable (drive),
      .onOut  (chanOnInt[g])
    );
  end

  // Output stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chanOn                <= 12'h000;
      channel_current_scale <= '0;
      global_current        <= 8'h00;
      analogEn              <= 1'b0;
      spread_range          <= 2'h0;
      spreadEn              <= 1'b0;
    end else begin
      chanOn                <= chanOnInt & {NUM_CH{drive}};
      channel_current_scale <= scale_r;
      global_current        <= gcc_r;
      analogEn              <= hw_shutdown_n;
      spread_range          <= spread_r[SPREAD_RNG_LSB +: 2];
      spreadEn              <= spread_r[4];
    end
  end

endmodule // lpcc_top

// File: lpcc_top_sva.sv
// Port assertions for the LED PWM channel controller
`timescale 1ns/1ps
module lpcc_top_sva
  import lpcc_pkg::*;
(
  input wire logic            ref_clk,       // clock
  input wire logic            rst,           // reset
  input wire logic            hw_shutdown_n, // shutdown pin
  input wire logic            scl,           // serial clock
  input wire logic            sdaOut,        // data drive level
  input wire logic            sdaOe,         // data pull enable
  input wire logic [11:0]     chanOn,        // channel enables
  input wire logic [11:0][7:0] channel_current_scale, // scales
  input wire logic [7:0]      global_current, // global current
  input wire logic            analogEn,      // analog enable
  input wire logic [1:0]      spread_range,  // spread code
  input wire logic            spreadEn       // spread enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic       scl_r;
  logic [3:0] sclAge_r;

  // Cycles since the last serial clock fall, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_r <= 1'b1;
      sclAge_r <= 4'hF;
    end else begin
      scl_r <= scl;
      if (scl_r && !scl) sclAge_r <= 4'h0;
      else if (sclAge_r != 4'hF) sclAge_r <= sclAge_r + 4'h1;
    end
  end

  sequence pinLow2;
    !hw_shutdown_n ##1 !hw_shutdown_n;
  endsequence
  sequence pinHigh2;
    hw_shutdown_n ##1 hw_shutdown_n;
  endsequence

  a_hw_off_analog: assert property (pinLow2 |-> !analogEn)
    else $error("analog enable high in hardware shutdown");
  a_hw_on_analog: assert property (pinHigh2 |-> analogEn)
    else $error("analog enable low after pin release");
  a_hw_off_dark: assert property (pinLow2 ##1 !hw_shutdown_n |-> chanOn == '0)
    else $error("channel on in hardware shutdown");
  a_reset_dark: assert property ($fell(rst) |-> (chanOn == '0) [*8])
    else $error("channel on right after reset");
  a_reg_quiet: assert property (
    $changed(channel_current_scale) || $changed(global_current) ||
    $changed(spread_range) || $changed(spreadEn) |-> sclAge_r < 4'h8)
    else $error("register output changed without a write");
  a_ack_rise: assert property ($rose(sdaOe) |-> !scl && sclAge_r < 4'h3)
    else $error("data pull started outside clock low start");
  a_ack_fall: assert property ($fell(sdaOe) |-> sclAge_r < 4'h3)
    else $error("data pull released away from clock fall");
  a_ack_hold: assert property ($rose(sdaOe) |-> sdaOe [*4])
    else $error("data pull too short");
  a_sda_zero: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
endmodule // lpcc_top_sva

bind lpcc_top lpcc_top_sva sva_u (
  .ref_clk(ref_clk), .rst(rst), .hw_shutdown_n(hw_shutdown_n),
  .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .chanOn(chanOn),
  .channel_current_scale(channel_current_scale),
  .global_current(global_current), .analogEn(analogEn),
  .spread_range(spread_range), .spreadEn(spreadEn)
);

// File: lpcc_host.sv
// Serial bus host model with open-drain data drive
`timescale 1ns/1ps
module lpcc_host
  import lpcc_pkg::*;
(
  input  wire logic ref_clk, // system clock
  input  wire logic sdaLine, // resolved data line
  output logic      scl,     // serial clock
  output logic      sdaLow   // host pulls data low
);
  logic nak;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    nak = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic put(input logic b);
    sdaLow = !b;
    hold(4);
    scl = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask

  task automatic get(output logic b);
    sdaLow = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(2);
    b = sdaLine;
    hold(2);
    scl = 1'b0;
  endtask

  task automatic start();
    sdaLow = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sdaLow = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sdaLow = 1'b0;
    hold(4);
  endtask

  task automatic tx(input logic [7:0] d);
    logic k;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(k);
    nak = nak | k;
  endtask

  task automatic wr(input logic [7:0] a, d);
    start();
    tx({DEV_ADDR_RST, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask

  // Pointer set by a write, then repeated start and one byte
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    tx({DEV_ADDR_RST, 1'b0});
    tx(a);
    start();
    tx({DEV_ADDR_RST, 1'b1});
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
  endtask
endmodule // lpcc_host

// File: lpcc_top_bench.sv
// Self-checking bench for the LED PWM channel controller
`timescale 1ns/1ps
module lpcc_top_bench;
  import lpcc_pkg::*;
  logic             ref_clk, rst, hw_shutdown_n;
  logic             scl, sdaLow, sdaOut, sdaOe, analogEn, spreadEn;
  logic [11:0]      ledOpenDet, ledShortDet, chanOn;
  logic [11:0][7:0] scale;
  logic [1:0]       range;
  logic [7:0]       gcur;
  wire              sdaLine;
  int               mismatches, comparisons;
  logic [15:0]      tops [4];

  // Open-drain data line with pull-up
  assign sdaLine = !sdaLow && !(sdaOe && !sdaOut);
  always #50 ref_clk = !ref_clk;

  lpcc_top dut_u (
    .ref_clk(ref_clk), .rst(rst), .hw_shutdown_n(hw_shutdown_n),
    .devAddr(DEV_ADDR_RST), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .ledOpenDet(ledOpenDet),
    .ledShortDet(ledShortDet), .chanOn(chanOn),
    .channel_current_scale(scale), .global_current(gcur),
    .analogEn(analogEn), .spread_range(range), .spreadEn(spreadEn)
  );
  lpcc_host host_u (
    .ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow)
  );

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, m, e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk({8'h0, d & m}, {8'h0, e});
  endtask

  task automatic meas(input int n, output logic [15:0] h0, h1,
                      output logic [9:0] oth);
    h0 = '0;
    h1 = '0;
    oth = '0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      h0 = h0 + {15'h0, chanOn[0]};
      h1 = h1 + {15'h0, chanOn[11]};
      oth = oth | chanOn[10:1];
    end
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  task automatic print_verdict();
    $display("%0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (99000) @(posedge ref_clk);
    mismatches++;
    $display("[ERR] %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    logic [2:0]  o;
    logic [1:0]  r;
    logic [15:0] h0, h1;
    logic [9:0]  oth;
    ref_clk = 1'b0;
    rst = 1'b1;
    hw_shutdown_n = 1'b1;
    ledOpenDet = 12'h5A5;
    ledShortDet = 12'hA5A;
    tops = '{TOP_8, TOP_10, TOP_12, TOP_16};
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    wt(2);
    rchk(OFS_CTRL, 8'hFF, CTRL_RST);
    rchk(OFS_SPREAD, 8'hFF, BYTE_RST);
    rchk(8'h60, 8'hFF, 8'h00);
    chk({4'h0, chanOn}, 16'h0);
    endt("reset");
    for (int n = 0; n < NUM_CH; n++) begin
      host_u.wr(8'(OFS_SCALE + n), {4'(n), 4'hA});
    end
    for (int n = 0; n < NUM_CH; n++) begin
      chk({8'h0, scale[n]}, {8'h0, 4'(n), 4'hA});
    end
    rchk(8'h58, 8'hFF, 8'hBA);
    for (int c = 0; c < 4; c++) begin
      host_u.wr(OFS_SPREAD, {3'h0, 1'b1, 2'(c), 2'h0});
      chk({14'h0, range}, 16'(c));
      chk({15'h0, spreadEn}, 16'h1);
    end
    endt("scale and spread");
    host_u.wr(OFS_PWM_BASE, 8'h04);
    host_u.wr(8'h1E, 8'h01);
    // Widest resolution last so the counter never sits above a top
    for (int i = 0; i < 5; i++) begin
      r = 2'(i > 0 ? i - 1 : 0);
      o = {2'h0, i == 1};
      host_u.wr(OFS_CTRL, {1'b0, o, 1'b0, r, 1'b1});
      wt(10);
      meas((int'(tops[r]) + 1) << o, h0, h1, oth);
      chk(h0, 16'h4 << o);
      chk(h1, (16'h0100 & tops[r]) << o);
      chk({6'h0, oth}, 16'h0);
    end
    endt("pwm");
    host_u.wr(OFS_CTRL, 8'h00);
    wt(4);
    meas(300, h0, h1, oth);
    chk(h0 | h1, 16'h0);
    host_u.wr(OFS_SCALE, 8'h5C);
    rchk(OFS_SCALE, 8'hFF, 8'h5C);
    rchk(OFS_PWM_BASE, 8'hFF, 8'h04);
    endt("soft shutdown");
    host_u.wr(OFS_CTRL, 8'h01);
    hw_shutdown_n = 1'b0;
    wt(3);
    chk({15'h0, analogEn}, 16'h0);
    chk({4'h0, chanOn}, 16'h0);
    host_u.wr(8'h4E, 8'hA7);
    host_u.wr(OFS_GCC, 8'h3C);
    rchk(8'h4E, 8'hFF, 8'hA7);
    hw_shutdown_n = 1'b1;
    wt(4);
    chk({15'h0, analogEn}, 16'h1);
    chk({8'h0, scale[1]}, 16'h00A7);
    chk({8'h0, gcur}, 16'h003C);
    rchk(OFS_CTRL, 8'hFF, 8'h01);
    endt("hard shutdown");
    host_u.wr(OFS_FDET, {6'h0, FDET_SHORT});
    rchk(OFS_FSTAT_LO, 8'hF8, 8'hD0);
    rchk(OFS_FSTAT_HI, 8'h7F, 8'h52);
    host_u.wr(OFS_FDET, 8'h00);
    host_u.wr(OFS_FDET, {6'h0, FDET_OPEN});
    rchk(OFS_FSTAT_LO, 8'hF8, 8'h28);
    rchk(OFS_FSTAT_HI, 8'h7F, 8'h2D);
    host_u.wr(OFS_FDET, 8'h00);
    ledOpenDet = 12'h000;
    host_u.wr(OFS_FDET, 8'h01);
    host_u.wr(OFS_FSTAT_LO, 8'h00);
    rchk(OFS_FSTAT_LO, 8'hF8, 8'h28);
    rchk(OFS_FDET, 8'hFF, 8'h01);
    endt("fault capture");
    host_u.wr(OFS_CTRL, 8'h00);
    host_u.wr(OFS_RESET, RESET_KEY);
    rchk(8'h4E, 8'hFF, 8'hA7);
    host_u.wr(OFS_CTRL, 8'h01);
    hw_shutdown_n = 1'b0;
    host_u.wr(OFS_RESET, RESET_KEY);
    hw_shutdown_n = 1'b1;
    wt(4);
    rchk(8'h4E, 8'hFF, 8'hA7);
    host_u.wr(OFS_RESET, RESET_KEY);
    rchk(8'h4E, 8'hFF, 8'h00);
    rchk(OFS_CTRL, 8'hFF, CTRL_RST);
    rchk(OFS_FSTAT_LO, 8'hF8, 8'h00);
    chk({8'h0, scale[1]}, 16'h0);
    chk({8'h0, gcur}, 16'h0);
    chk({15'h0, host_u.nak}, 16'h0);
    endt("register reset");
    print_verdict();
  end
endmodule // lpcc_top_bench
